// *** src/izs_pkg.sv ***
// Constants and types for the increment / increment-skip-zero decode block.
// Assumes a single 40 MHz core clock; one instruction cycle is four phases.
//
// Operation
// - Plain increment: decode Q1, read file Q2, compute Q3, write destination Q4.
// - Skip variant opcode is nibbles 0011 and 11da, then 8-bit file address.
// - Operand plus one; destination bit clear writes working register, set writes file.
// - Skip variant: zero result discards prefetched next instruction and runs a no-operation instead.
// - Skip variant takes one cycle without skip, two when skipping one word.
// - Access bit clear uses access bank; set uses bank select register bank.
// - Extended set, access clear, address at most 95 selects indexed literal offset.
// - Skipping a two-word instruction costs three cycles in total.
// - Skipping a three-word instruction costs four cycles in total.
package izs_pkg;

    // ----------------------------------------
    // Opcode fields
    // ----------------------------------------
    localparam logic [5:0] IZS_OPC_INC      = 6'h0a;  // 0010 10da
    localparam logic [5:0] IZS_OPC_INC_SKIP = 6'h0f;  // 0011 11da
    localparam int         IZS_OPC_MSB      = 15;
    localparam int         IZS_OPC_LSB      = 10;
    localparam int         IZS_DEST_BIT     = 9;
    localparam int         IZS_ACCESS_BIT   = 8;
    localparam logic [7:0] IZS_IDX_LIMIT    = 8'h5f;
    localparam logic [7:0] IZS_ACCESS_SPLIT = 8'h60;  // Low access half is bank 0
    localparam logic [3:0] IZS_SFR_BANK     = 4'hf;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] IZS_W_RESET      = 8'h00;
    localparam logic [4:0] IZS_FLAGS_RESET  = 5'h00;
    localparam int         IZS_SYNC_STAGES  = 2;

    // Four phases of one instruction cycle
    typedef enum logic [1:0] {IZS_Q1, IZS_Q2, IZS_Q3, IZS_Q4} izs_phase_e;

    // Data-memory addressing modes
    typedef enum logic [1:0] {IZS_AM_ACCESS, IZS_AM_BANKED, IZS_AM_INDEXED} izs_amode_e;

    // Flag order {N, OV, Z, DC, C}
    localparam int IZS_F_C  = 0;
    localparam int IZS_F_DC = 1;
    localparam int IZS_F_Z  = 2;
    localparam int IZS_F_OV = 3;
    localparam int IZS_F_N  = 4;

endpackage : izs_pkg

// *** src/izs_mem_if.sv ***
// Data-memory port between the sequencer and the address former.
// Assumes both ends run on the core clock.
`timescale 1ns/100ps
interface izs_mem_if;
    logic [7:0]  file_addr;
    logic        access_bit;
    logic [3:0]  bank_sel;
    logic        ext_en;
    logic [11:0] fsr2;
    logic [11:0] phys_addr;
    izs_pkg::izs_amode_e mode;

    modport seq (output file_addr, output access_bit, output bank_sel, output ext_en,
                 output fsr2, input phys_addr, input mode);
    modport addr (input file_addr, input access_bit, input bank_sel, input ext_en,
                  input fsr2, output phys_addr, output mode);
endinterface : izs_mem_if

// *** src/izs_addr.sv ***
// Forms the 12-bit data-memory address from a byte-oriented operand.
// Assumes inputs are stable for the whole instruction cycle.
`timescale 1ns/100ps
module izs_addr
    import izs_pkg::*;
(
    izs_mem_if.addr m
);
    // ----------------------------------------
    // Address mode select
    // ----------------------------------------
    always_comb
    begin
        if (!m.access_bit && m.ext_en && m.file_addr <= IZS_IDX_LIMIT)
        begin
            m.mode      = IZS_AM_INDEXED;
            m.phys_addr = m.fsr2 + {4'h0, m.file_addr};
        end
        else if (m.access_bit)
        begin
            m.mode      = IZS_AM_BANKED;
            m.phys_addr = {m.bank_sel, m.file_addr};
        end
        else
        begin
            // Access bank: low half bank 0, high half special registers
            m.mode      = IZS_AM_ACCESS;
            m.phys_addr = (m.file_addr < IZS_ACCESS_SPLIT) ? {4'h0, m.file_addr}
                                                            : {IZS_SFR_BANK, m.file_addr};
        end
    end

endmodule : izs_addr

// *** src/izs_core.sv ***
// Sequencer for increment and increment-skip-zero instructions.
// Assumes fetch supplies a word at each Q1 with the length of the follower.
`timescale 1ns/100ps
module izs_core
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] instr_i,        // Word decoded in Q1
    input  wire logic [1:0]  next_words_i,   // Length of prefetched follower, 1..3
    input  wire logic [3:0]  bank_select_register_i,
    input  wire logic        ext_set_en_i,
    input  wire logic [11:0] fsr2_i,
    input  wire logic [7:0]  mem_rdata_i,
    output logic [11:0]      mem_addr_o,
    output logic             mem_rd_o,
    output logic             mem_wr_o,
    output logic [7:0]       mem_wdata_o,
    output logic [7:0]       wreg_o,
    output logic [4:0]       flags_o,
    output logic [1:0]       phase_o,
    output logic             nop_cycle_o,    // Current cycle is a flushed no-op
    output logic             busy_o
);
    import izs_pkg::*;

    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    logic [IZS_SYNC_STAGES-1:0] rst_sync_reg;
    logic                       rst_n;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_reg <= '0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // ----------------------------------------
    // Phase counter and decode
    // ----------------------------------------
    izs_phase_e  phase_reg;
    logic [15:0] ir_reg;
    logic        is_inc_reg, is_skip_reg;
    logic [1:0]  flush_cnt_reg;   // No-op cycles still to run
    logic [7:0]  operand_reg, result_reg;
    logic [4:0]  flags_next;
    logic [15:0] dec_word;        // Word that forms the operand address
    logic        dec_hit;         // Recognised opcode on instr_i while no flush is pending, in any phase
    izs_mem_if   mif();

    // Decode on phase one of a non-flushed cycle
    function automatic logic match(input logic [15:0] w, input logic [5:0] opc);
        match = (w[IZS_OPC_MSB:IZS_OPC_LSB] == opc);
    endfunction : match

    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            phase_reg <= IZS_Q1;
        else
            phase_reg <= izs_phase_e'(phase_reg + 2'd1);
    end

    // Instruction capture in Q1
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ir_reg      <= 16'h0000;
            is_inc_reg  <= 1'b0;
            is_skip_reg <= 1'b0;
        end
        else if (phase_reg == IZS_Q1)
        begin
            ir_reg      <= instr_i;
            is_inc_reg  <= (flush_cnt_reg == 2'd0) && match(instr_i, IZS_OPC_INC);
            is_skip_reg <= (flush_cnt_reg == 2'd0) && match(instr_i, IZS_OPC_INC_SKIP);
        end
    end

    // Address from the incoming word in Q1, so the Q2 read sees the new operand
    assign dec_word       = (phase_reg == IZS_Q1) ? instr_i : ir_reg;
    assign dec_hit        = (flush_cnt_reg == 2'd0)
                            && (match(instr_i, IZS_OPC_INC) || match(instr_i, IZS_OPC_INC_SKIP));
    assign mif.file_addr  = dec_word[7:0];
    assign mif.access_bit = dec_word[IZS_ACCESS_BIT];
    assign mif.bank_sel   = bank_select_register_i;
    assign mif.ext_en     = ext_set_en_i;
    assign mif.fsr2       = fsr2_i;

    izs_addr u_addr (.m(mif.addr));

    // ----------------------------------------
    // Read in Q2, compute in Q3
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            operand_reg <= 8'h00;
            result_reg  <= 8'h00;
        end
        else
        begin
            if (phase_reg == IZS_Q2)
                operand_reg <= mem_rdata_i;
            if (phase_reg == IZS_Q3)
                result_reg  <= operand_reg + 8'h01;
        end
    end

    // Flag update for the plain increment only
    always_comb
    begin
        flags_next          = flags_o;
        flags_next[IZS_F_C]  = (operand_reg == 8'hff);
        flags_next[IZS_F_DC] = (operand_reg[3:0] == 4'hf);
        flags_next[IZS_F_Z]  = (result_reg == 8'h00);
        flags_next[IZS_F_OV] = (operand_reg == 8'h7f);
        flags_next[IZS_F_N]  = result_reg[7];
    end

    // ----------------------------------------
    // Write in Q4 and flush scheduling
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wreg_o        <= IZS_W_RESET;
            flags_o       <= IZS_FLAGS_RESET;
            flush_cnt_reg <= 2'd0;
        end
        else if (phase_reg == IZS_Q4)
        begin
            if ((is_inc_reg || is_skip_reg) && !ir_reg[IZS_DEST_BIT])
                wreg_o <= result_reg;
            if (is_inc_reg)
                flags_o <= flags_next;
            if (is_skip_reg && result_reg == 8'h00)
                flush_cnt_reg <= (next_words_i == 2'd0) ? 2'd1 : next_words_i;
            else if (flush_cnt_reg != 2'd0)
                flush_cnt_reg <= flush_cnt_reg - 2'd1;
        end
    end

    // Memory strobes and status, registered one phase ahead
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_addr_o  <= 12'h000;
            mem_rd_o    <= 1'b0;
            mem_wr_o    <= 1'b0;
            mem_wdata_o <= 8'h00;
            phase_o     <= 2'd0;
            nop_cycle_o <= 1'b0;
            busy_o      <= 1'b0;
        end
        else
        begin
            phase_o     <= 2'(phase_reg + 2'd1);
            mem_addr_o  <= mif.phys_addr;
            mem_rd_o    <= (phase_reg == IZS_Q1) && dec_hit;
            mem_wr_o    <= (phase_reg == IZS_Q3) && (is_inc_reg || is_skip_reg)
                           && ir_reg[IZS_DEST_BIT];
            mem_wdata_o <= operand_reg + 8'h01;
            if (phase_reg == IZS_Q4)
                nop_cycle_o <= (is_skip_reg && result_reg == 8'h00) || (flush_cnt_reg > 2'd1);
            // High from Q2 of a live instruction through its last flushed cycle
            if (phase_reg == IZS_Q1)
                busy_o  <= dec_hit || (flush_cnt_reg != 2'd0);
            else if (phase_reg == IZS_Q4)
                busy_o  <= (is_skip_reg && result_reg == 8'h00) || (flush_cnt_reg > 2'd1);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_skip_flags;
        @(posedge sys_clk_i) disable iff (!rst_n)
        (phase_reg == IZS_Q4 && is_skip_reg) |=> $stable(flags_o);
    endproperty
    a_skip_flags: assert property (p_skip_flags) else $error("skip changed flags");

    property p_wrap;
        @(posedge sys_clk_i) disable iff (!rst_n)
        (phase_reg == IZS_Q3) |=> (result_reg == 8'($past(operand_reg) + 8'h01));
    endproperty
    a_wrap: assert property (p_wrap) else $error("bad increment");

    property p_write;
        @(posedge sys_clk_i) disable iff (!rst_n)
        mem_wr_o |-> (phase_reg == IZS_Q4) && ir_reg[IZS_DEST_BIT];
    endproperty
    a_write: assert property (p_write) else $error("write out of Q4");

    property p_skip_one;
        @(posedge sys_clk_i) disable iff (!rst_n)
        (phase_reg == IZS_Q4 && is_skip_reg && result_reg == 8'h00 && next_words_i == 2'd1)
        |=> nop_cycle_o ##4 !nop_cycle_o;
    endproperty
    a_skip_one: assert property (p_skip_one) else $error("one-word skip length");

    property p_skip_two;
        @(posedge sys_clk_i) disable iff (!rst_n)
        (phase_reg == IZS_Q4 && is_skip_reg && result_reg == 8'h00 && next_words_i == 2'd2)
        |=> nop_cycle_o [*8] ##1 !nop_cycle_o;
    endproperty
    a_skip_two: assert property (p_skip_two) else $error("two-word skip length");

    property p_skip_three;
        @(posedge sys_clk_i) disable iff (!rst_n)
        (phase_reg == IZS_Q4 && is_skip_reg && result_reg == 8'h00 && next_words_i == 2'd3)
        |=> nop_cycle_o [*8] ##4 nop_cycle_o ##4 !nop_cycle_o;
    endproperty
    a_skip_three: assert property (p_skip_three) else $error("three-word skip length");

    property p_noskip;
        @(posedge sys_clk_i) disable iff (!rst_n)
        (phase_reg == IZS_Q4 && is_skip_reg && result_reg != 8'h00 && flush_cnt_reg == 2'd0)
        |=> !nop_cycle_o;
    endproperty
    a_noskip: assert property (p_noskip) else $error("spurious skip");

    property p_index;
        @(posedge sys_clk_i) disable iff (!rst_n)
        (ext_set_en_i && !mif.access_bit && mif.file_addr <= IZS_IDX_LIMIT)
        |-> mif.mode == IZS_AM_INDEXED;
    endproperty
    a_index: assert property (p_index) else $error("indexed mode missed");

    property p_banked;
        @(posedge sys_clk_i) disable iff (!rst_n)
        mif.access_bit |-> mif.phys_addr == {bank_select_register_i, mif.file_addr};
    endproperty
    a_banked: assert property (p_banked) else $error("bank address wrong");

endmodule : izs_core

// *** test/tb.sv ***
// Self-checking bench for the increment and increment-skip-zero sequencer.
// Assumes the design carries its own assertions; inputs change at falling edges.
`timescale 1ns/100ps
module tb;
    import izs_pkg::*;

    // ----------------------------------------
    // Signals and bench state
    // ----------------------------------------
    logic        sys_clk_i              = 1'b0;
    logic        rst_n_i                = 1'b0;
    logic [15:0] instr_i                = 16'h0000;
    logic [1:0]  next_words_i           = 2'h1;
    logic [3:0]  bank_select_register_i = 4'h0;
    logic        ext_set_en_i           = 1'b0;
    logic [11:0] fsr2_i                 = 12'h000;
    logic [7:0]  mem_rdata_i            = 8'h00;
    logic [11:0] mem_addr_o;
    logic        mem_rd_o, mem_wr_o, nop_cycle_o, busy_o;
    logic [7:0]  mem_wdata_o, wreg_o;
    logic [4:0]  flags_o;
    logic [1:0]  phase_o;
    logic [31:0] seed                   = 32'd93214;
    logic [7:0]  exp_w                  = IZS_W_RESET;
    logic [4:0]  exp_f                  = IZS_FLAGS_RESET;
    int          n_errors               = 0;
    int          compares               = 0;
    int          cyc                    = 0;
    localparam int LIMIT = 10000;  // About eight times the expected run

    izs_core i_izs_core (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
        .next_words_i(next_words_i), .bank_select_register_i(bank_select_register_i),
        .ext_set_en_i(ext_set_en_i), .fsr2_i(fsr2_i), .mem_rdata_i(mem_rdata_i),
        .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
        .mem_wdata_o(mem_wdata_o), .wreg_o(wreg_o), .flags_o(flags_o),
        .phase_o(phase_o), .nop_cycle_o(nop_cycle_o), .busy_o(busy_o)
    );

    // 40 MHz clock
    always #12.5 sys_clk_i = ~sys_clk_i;

    // ----------------------------------------
    // Reference functions and checks
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Physical address seen in Q2, from the levels held over the cycle
    function automatic logic [11:0] exp_addr(input logic a, input logic [7:0] f);
        if (a) return {bank_select_register_i, f};
        if (ext_set_en_i && f <= IZS_IDX_LIMIT) return fsr2_i + {4'h0, f};
        if (f < IZS_ACCESS_SPLIT) return {4'h0, f};
        return {IZS_SFR_BANK, f};
    endfunction : exp_addr

    // Flags {N, OV, Z, DC, C} after a plain increment of v
    function automatic logic [4:0] inc_flags(input logic [7:0] v);
        logic [7:0] r;
        r = v + 8'h01;
        return {r[7], v == 8'h7f, r == 8'h00, v[3:0] == 4'hf, v == 8'hff};
    endfunction : inc_flags

    task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic end_sim();
        if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    // Hang guard
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_errors++;
            end_sim();
        end
    end

    // ----------------------------------------
    // One instruction, entered at a falling edge in Q1
    // ----------------------------------------
    task automatic do_op(input logic skip, input logic d, input logic a,
                         input logic [7:0] f, input logic [7:0] v, input logic [1:0] w);
        logic [7:0] r;
        int         n;
        r = v + 8'h01;
        n = (w == 2'h0) ? 1 : int'(w);
        chk_val(12'(phase_o), 12'(IZS_Q1));
        instr_i = {skip ? IZS_OPC_INC_SKIP : IZS_OPC_INC, d, a, f};
        next_words_i = w;
        mem_rdata_i = v;
        bank_select_register_i = 4'(rnd());
        ext_set_en_i = 1'(rnd());
        fsr2_i = 12'(rnd());
        @(negedge sys_clk_i);
        instr_i = 16'h0000;
        chk_bit(mem_rd_o, 1'b1);
        chk_bit(busy_o, 1'b1);
        chk_val(mem_addr_o, exp_addr(a, f));
        @(negedge sys_clk_i);
        mem_rdata_i = ~v;  // Operand gone once it has been read
        @(negedge sys_clk_i);
        chk_bit(mem_wr_o, d);
        if (d) chk_val(12'(mem_wdata_o), 12'(r));
        @(negedge sys_clk_i);
        if (!d) exp_w = r;
        if (!skip) exp_f = inc_flags(v);
        chk_val(12'(wreg_o), 12'(exp_w));
        chk_val(12'(flags_o), 12'(exp_f));
        if (skip && r == 8'h00)
        begin
            // Decoy increments offered at each flushed Q1 must be dropped
            for (int i = 0; i < 4 * n; i++)
            begin
                instr_i = (i % 4 == 0) ? {IZS_OPC_INC, 2'b01, 8'(rnd())} : 16'h0000;
                chk_bit(nop_cycle_o, 1'b1);
                chk_bit(busy_o, 1'b1);
                chk_bit(mem_rd_o, 1'b0);
                @(negedge sys_clk_i);
            end
            instr_i = 16'h0000;
        end
        chk_bit(nop_cycle_o, 1'b0);
        chk_bit(busy_o, 1'b0);
    endtask : do_op

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] rv;
        repeat (16) @(negedge sys_clk_i);
        chk_val(12'(wreg_o), 12'(IZS_W_RESET));
        chk_val(12'(flags_o), 12'(IZS_FLAGS_RESET));
        rst_n_i = 1'b1;
        for (int i = 0; i < 20 && phase_o !== 2'd1; i++) @(negedge sys_clk_i);
        for (int i = 0; i < 8 && phase_o !== 2'd0; i++) @(negedge sys_clk_i);
        do_op(1'b0, 1'b1, 1'b0, 8'h20, 8'hff, 2'h1);
        do_op(1'b0, 1'b0, 1'b1, 8'h60, 8'h7f, 2'h1);
        do_op(1'b0, 1'b0, 1'b0, 8'h5f, 8'h0f, 2'h1);
        for (int w = 0; w < 4; w++) do_op(1'b1, w[0], 1'b0, 8'h61, 8'hff, 2'(w));
        do_op(1'b1, 1'b0, 1'b0, 8'h10, 8'hfe, 2'h3);
        repeat (200)
        begin
            rv = rnd();
            do_op(rv[0], rv[1], rv[2], rv[15:8], rv[3] ? 8'hff : rv[23:16], rv[5:4]);
        end
        end_sim();
    end

endmodule : tb
